// file: src/sdrs_status_regs.sv
`timescale 1ns/1ps
`include "sdrs_params.svh"

module sdrs_status_regs #(
  parameter logic BUILD_WITH_ERROR_PACKET_PROCESSOR = 1'b1
) (
  input  logic                         clk,
  input  logic                         reset_n,
  // AXI4-Lite write address
  input  logic [6:0]                   s_axi_awaddr,
  input  logic                         s_axi_awvalid,
  output logic                         s_axi_awready,
  // AXI4-Lite write data
  input  logic [31:0]                  s_axi_wdata,
  input  logic [3:0]                   s_axi_wstrb,
  input  logic                         s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  logic                         s_axi_bready,
  // AXI4-Lite read address
  input  logic [6:0]                   s_axi_araddr,
  input  logic                         s_axi_arvalid,
  output logic                         s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  logic                         s_axi_rready,
  // module control: mode detection enable
  input  logic                         mode_det_enable,
  // mode detector
  input  sdrs_pkg::sdrs_rate_mode_t    det_mode,
  input  logic                         det_mode_locked,
  input  logic                         det_level_b,
  input  sdrs_pkg::sdrs_stream_count_t det_streams,
  // transport detector
  input  logic [3:0]                   ts_rate,
  input  logic [3:0]                   ts_family,
  input  logic                         ts_scan,
  input  logic                         ts_locked,
  // payload identifier extractor, stream 15
  input  logic [31:0]                  payload_in,
  input  logic                         payload_in_ok
);
  import sdrs_pkg::*;

  // ****************************************************
  // status fields
  // ****************************************************
  sdrs_rate_mode_t    rate_mode;       // registered line rate
  logic               mode_locked;     // registered lock
  logic               level_b_3g_flag; // registered level B
  sdrs_stream_count_t active_stream_count; // registered count
  logic [3:0]         t_rate;          // transport frame rate
  logic [3:0]         t_family;        // transport family
  logic               t_scan;          // transport scan
  logic               t_locked;        // transport locked
  logic [31:0]        stream15_payload_bytes; // captured word
  logic               stream15_payload_valid; // capture valid

  // ****************************************************
  // bus state
  // ****************************************************
  sdrs_rd_state_t rd_state;       // read channel state
  sdrs_rd_state_t next_rd_state;  // read next state
  logic [31:0]    next_rdata;     // read data next
  logic [1:0]     next_rresp;     // read response next
  sdrs_wr_state_t wr_state;       // write channel state
  sdrs_wr_state_t next_wr_state;  // write next state
  logic [6:0]     wr_addr;        // latched write address
  logic [6:0]     next_wr_addr;   // write address next
  logic [1:0]     next_bresp;     // write response next
  logic [32:0]    rd_word;        // decode hit and data

  // ****************************************************
  // field sources
  // ****************************************************
  // status fields sampled from the detectors
  sdrs_status_sync u_status (
    .clk                 (clk),
    .reset_n             (reset_n),
    .mode_det_enable     (mode_det_enable),
    .det_mode            (det_mode),
    .det_mode_locked     (det_mode_locked),
    .det_level_b         (det_level_b),
    .det_streams         (det_streams),
    .ts_rate             (ts_rate),
    .ts_family           (ts_family),
    .ts_scan             (ts_scan),
    .ts_locked           (ts_locked),
    .rate_mode           (rate_mode),
    .mode_locked         (mode_locked),
    .level_b_3g_flag     (level_b_3g_flag),
    .active_stream_count (active_stream_count),
    .t_rate              (t_rate),
    .t_family            (t_family),
    .t_scan              (t_scan),
    .t_locked            (t_locked)
  );

  // payload identifier word for stream 15
  sdrs_payload_capture u_capture (
    .clk                    (clk),
    .reset_n                (reset_n),
    .payload_in             (payload_in),
    .payload_in_ok          (payload_in_ok),
    .stream15_payload_bytes (stream15_payload_bytes),
    .stream15_payload_valid (stream15_payload_valid)
  );

  // ****************************************************
  // address decode
  // ****************************************************
  // true when the word address matches a register offset
  function automatic logic word_hit(input logic [6:0] addr,
                                    input logic [6:0] off);
    word_hit = (addr[6:2] == off[6:2]);
  endfunction

  // true for any mapped register
  function automatic logic is_mapped(input logic [6:0] addr);
    is_mapped = word_hit(addr, `SDRS_OFF_PAYLOAD_VALID) ||
                word_hit(addr, `SDRS_OFF_STREAM15) ||
                word_hit(addr, `SDRS_OFF_VERSION) ||
                word_hit(addr, `SDRS_OFF_BUILD_CFG) ||
                word_hit(addr, `SDRS_OFF_RATE_MODE) ||
                word_hit(addr, `SDRS_OFF_TRANSPORT);
  endfunction

  // ****************************************************
  // read mux
  // ****************************************************
  // reserved bits stay zero because each word starts cleared
  always_comb begin
    rd_word = {is_mapped(s_axi_araddr), 32'h0000_0000};
    if (word_hit(s_axi_araddr, `SDRS_OFF_PAYLOAD_VALID)) begin
      rd_word[`SDRS_POS_VALID_DS15] = stream15_payload_valid;
    end
    if (word_hit(s_axi_araddr, `SDRS_OFF_STREAM15)) begin
      rd_word[31:0] = stream15_payload_bytes;
    end
    if (word_hit(s_axi_araddr, `SDRS_OFF_VERSION)) begin
      rd_word[31:0] = {`SDRS_VER_MAJOR, `SDRS_VER_MINOR,
                       `SDRS_VER_REV, `SDRS_VER_PATCH,
                       `SDRS_VER_INTERNAL};
    end
    if (word_hit(s_axi_araddr, `SDRS_OFF_BUILD_CFG)) begin
      rd_word[`SDRS_POS_EDH_PRESENT] =
        BUILD_WITH_ERROR_PACKET_PROCESSOR;
    end
    if (word_hit(s_axi_araddr, `SDRS_OFF_RATE_MODE)) begin
      rd_word[`SDRS_POS_LEVEL_B] = level_b_3g_flag;
      rd_word[`SDRS_POS_STREAMS_LO +: 3] =
        active_stream_count;
      rd_word[`SDRS_POS_MODE_LOCKED] = mode_locked;
      rd_word[`SDRS_POS_MODE_LO +: 3] = rate_mode;
    end
    if (word_hit(s_axi_araddr, `SDRS_OFF_TRANSPORT)) begin
      rd_word[`SDRS_POS_T_RATE_LO +: 4] = t_rate;
      rd_word[`SDRS_POS_T_FAMILY_LO +: 4] = t_family;
      rd_word[`SDRS_POS_T_SCAN] = t_scan;
      rd_word[`SDRS_POS_T_LOCKED] = t_locked;
    end
  end

  // ****************************************************
  // read channel
  // ****************************************************
  // address accepted only while idle; data held until taken
  assign s_axi_arready = (rd_state == SDRS_RD_IDLE);
  assign s_axi_rvalid  = (rd_state == SDRS_RD_DATA);

  // next read state and captured answer
  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    case (rd_state)
      SDRS_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_rd_state = SDRS_RD_DATA;
          next_rdata    = rd_word[31:0];
          // unmapped words answer with a slave error
          next_rresp    = rd_word[32] ? `SDRS_RESP_OKAY
                                      : `SDRS_RESP_SLVERR;
        end
      end
      SDRS_RD_DATA: begin
        if (s_axi_rready) begin
          next_rd_state = SDRS_RD_IDLE;
        end
      end
      default: begin
        next_rd_state = SDRS_RD_IDLE;
      end
    endcase
  end

  // register read state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_state    <= SDRS_RD_IDLE;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SDRS_RESP_OKAY;
    end else begin
      rd_state    <= next_rd_state;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ****************************************************
  // write channel
  // ****************************************************
  // address and data may come in either order or together
  assign s_axi_awready = (wr_state == SDRS_WR_IDLE) ||
                         (wr_state == SDRS_WR_GOT_DATA);
  assign s_axi_wready  = (wr_state == SDRS_WR_IDLE) ||
                         (wr_state == SDRS_WR_GOT_ADDR);
  assign s_axi_bvalid  = (wr_state == SDRS_WR_RESP);

  // next write state; the data never reaches any register
  always_comb begin
    next_wr_state = wr_state;
    next_wr_addr  = wr_addr;
    next_bresp    = s_axi_bresp;
    case (wr_state)
      SDRS_WR_IDLE: begin
        if (s_axi_awvalid) begin
          next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_awvalid && s_axi_wvalid) begin
          next_wr_state = SDRS_WR_RESP;
          next_bresp    = is_mapped(s_axi_awaddr)
                          ? `SDRS_RESP_OKAY : `SDRS_RESP_SLVERR;
        end else if (s_axi_awvalid) begin
          next_wr_state = SDRS_WR_GOT_ADDR;
        end else if (s_axi_wvalid) begin
          next_wr_state = SDRS_WR_GOT_DATA;
        end
      end
      SDRS_WR_GOT_ADDR: begin
        if (s_axi_wvalid) begin
          next_wr_state = SDRS_WR_RESP;
          next_bresp    = is_mapped(wr_addr)
                          ? `SDRS_RESP_OKAY : `SDRS_RESP_SLVERR;
        end
      end
      SDRS_WR_GOT_DATA: begin
        if (s_axi_awvalid) begin
          next_wr_addr  = s_axi_awaddr;
          next_wr_state = SDRS_WR_RESP;
          next_bresp    = is_mapped(s_axi_awaddr)
                          ? `SDRS_RESP_OKAY : `SDRS_RESP_SLVERR;
        end
      end
      SDRS_WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = SDRS_WR_IDLE;
        end
      end
      default: begin
        next_wr_state = SDRS_WR_IDLE;
      end
    endcase
  end

  // register write state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_state    <= SDRS_WR_IDLE;
      wr_addr     <= 7'h00;
      s_axi_bresp <= `SDRS_RESP_OKAY;
    end else begin
      wr_state    <= next_wr_state;
      wr_addr     <= next_wr_addr;
      s_axi_bresp <= next_bresp;
    end
  end

endmodule

// file: src/sdrs_params.svh
`ifndef SDRS_PARAMS_SVH
`define SDRS_PARAMS_SVH

// ****************************************************
// bus geometry
// ****************************************************
`define SDRS_ADDR_W        7
`define SDRS_DATA_W        32

// ****************************************************
// register byte offsets
// ****************************************************
`define SDRS_OFF_PAYLOAD_VALID  7'h18
`define SDRS_OFF_STREAM15       7'h38
`define SDRS_OFF_VERSION        7'h3C
`define SDRS_OFF_BUILD_CFG      7'h40
`define SDRS_OFF_RATE_MODE      7'h44
`define SDRS_OFF_TRANSPORT      7'h48

// ****************************************************
// field positions
// ****************************************************
`define SDRS_POS_VALID_DS15     7
`define SDRS_POS_EDH_PRESENT    1
`define SDRS_POS_LEVEL_B        7
`define SDRS_POS_STREAMS_LO     4
`define SDRS_POS_MODE_LOCKED    3
`define SDRS_POS_MODE_LO        0
`define SDRS_POS_T_RATE_LO      8
`define SDRS_POS_T_FAMILY_LO    4
`define SDRS_POS_T_SCAN         1
`define SDRS_POS_T_LOCKED       0

// ****************************************************
// reset values
// ****************************************************
`define SDRS_RST_STREAM15       32'h0000_0000
`define SDRS_RST_STREAMS        3'h1
`define SDRS_RST_MODE_LOCKED    1'b1
`define SDRS_RST_MODE           3'h0
`define SDRS_RST_T_RATE         4'h0
`define SDRS_RST_T_FAMILY       4'hF

// ****************************************************
// version fields (values arbitrary)
// ****************************************************
`define SDRS_VER_MAJOR          8'h05
`define SDRS_VER_MINOR          8'h03
`define SDRS_VER_REV            4'h2
`define SDRS_VER_PATCH          4'h1
`define SDRS_VER_INTERNAL       8'h07

// ****************************************************
// AXI response codes
// ****************************************************
`define SDRS_RESP_OKAY          2'h0
`define SDRS_RESP_SLVERR        2'h2

`endif

// file: src/sdrs_pkg.sv
package sdrs_pkg;

  // ****************************************************
  // field types
  // ****************************************************
  // detected line-rate mode
  typedef enum logic [2:0] {
    SDRS_MODE_HD      = 3'h0,
    SDRS_MODE_SD      = 3'h1,
    SDRS_MODE_3G      = 3'h2,
    SDRS_MODE_6G      = 3'h4,
    SDRS_MODE_12G     = 3'h5,
    SDRS_MODE_12G_DIV = 3'h6
  } sdrs_rate_mode_t;

  // active data stream count code
  typedef enum logic [2:0] {
    SDRS_STREAMS_1  = 3'h0,
    SDRS_STREAMS_2  = 3'h1,
    SDRS_STREAMS_4  = 3'h2,
    SDRS_STREAMS_8  = 3'h3,
    SDRS_STREAMS_16 = 3'h4
  } sdrs_stream_count_t;

  // ****************************************************
  // bus state machines
  // ****************************************************
  typedef enum logic [1:0] {
    SDRS_RD_IDLE = 2'h0,
    SDRS_RD_DATA = 2'h1
  } sdrs_rd_state_t;

  typedef enum logic [1:0] {
    SDRS_WR_IDLE     = 2'h0,
    SDRS_WR_GOT_ADDR = 2'h1,
    SDRS_WR_RESP     = 2'h3,
    SDRS_WR_GOT_DATA = 2'h2
  } sdrs_wr_state_t;

endpackage

// file: src/sdrs_payload_capture.sv
`timescale 1ns/1ps
`include "sdrs_params.svh"

module sdrs_payload_capture (
  input  logic        clk,           // bus clock
  input  logic        reset_n,       // async reset, active low
  input  logic [31:0] payload_in,    // extractor payload bytes
  input  logic        payload_in_ok, // extractor says bytes valid
  output logic [31:0] stream15_payload_bytes, // last captured word
  output logic        stream15_payload_valid  // capture valid flag
);
  import sdrs_pkg::*;

  logic [31:0] next_bytes;  // next captured word
  logic        next_valid;  // next valid flag

  // ****************************************************
  // capture next values
  // ****************************************************
  // take the word while valid, otherwise hold the last one
  always_comb begin
    next_bytes = stream15_payload_bytes;
    next_valid = payload_in_ok;
    if (payload_in_ok) begin
      next_bytes = payload_in;
    end
  end

  // register the capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stream15_payload_bytes <= `SDRS_RST_STREAM15;
      stream15_payload_valid <= 1'b0;
    end else begin
      stream15_payload_bytes <= next_bytes;
      stream15_payload_valid <= next_valid;
    end
  end

endmodule

// file: src/sdrs_status_sync.sv
`timescale 1ns/1ps
`include "sdrs_params.svh"

module sdrs_status_sync (
  input  logic                        clk,
  input  logic                        reset_n,
  input  logic                        mode_det_enable,
  input  sdrs_pkg::sdrs_rate_mode_t   det_mode,
  input  logic                        det_mode_locked,
  input  logic                        det_level_b,
  input  sdrs_pkg::sdrs_stream_count_t det_streams,
  input  logic [3:0]                  ts_rate,
  input  logic [3:0]                  ts_family,
  input  logic                        ts_scan,
  input  logic                        ts_locked,
  output sdrs_pkg::sdrs_rate_mode_t   rate_mode,
  output logic                        mode_locked,
  output logic                        level_b_3g_flag,
  output sdrs_pkg::sdrs_stream_count_t active_stream_count,
  output logic [3:0]                  t_rate,
  output logic [3:0]                  t_family,
  output logic                        t_scan,
  output logic                        t_locked
);
  import sdrs_pkg::*;

  logic next_mode_locked;  // lock as seen by software

  // ****************************************************
  // lock override
  // ****************************************************
  // lock forced high while mode detection is disabled
  always_comb begin
    next_mode_locked = mode_det_enable ? det_mode_locked : 1'b1;
  end

  // register all status fields with their reset codes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_mode           <= sdrs_rate_mode_t'(`SDRS_RST_MODE);
      mode_locked         <= `SDRS_RST_MODE_LOCKED;
      level_b_3g_flag     <= 1'b0;
      active_stream_count <= sdrs_stream_count_t'(`SDRS_RST_STREAMS);
      t_rate              <= `SDRS_RST_T_RATE;
      t_family            <= `SDRS_RST_T_FAMILY;
      t_scan              <= 1'b0;
      t_locked            <= 1'b0;
    end else begin
      rate_mode           <= det_mode;
      mode_locked         <= next_mode_locked;
      level_b_3g_flag     <= det_level_b;
      active_stream_count <= det_streams;
      t_rate              <= ts_rate;
      t_family            <= ts_family;
      t_scan              <= ts_scan;
      t_locked            <= ts_locked;
    end
  end

endmodule

// file: testbench/sdrs_status_regs_properties.sv
`timescale 1ns/1ps
`include "sdrs_params.svh"

// ****
// checker
// ****
module sdrs_status_regs_checker #(
  parameter logic BUILD_WITH_ERROR_PACKET_PROCESSOR = 1'b1
) (
  input logic                         clk,
  input logic                         reset_n,
  input logic [6:0]                   s_axi_araddr,
  input logic                         s_axi_arvalid,
  input logic                         s_axi_arready,
  input logic [31:0]                  s_axi_rdata,
  input logic [1:0]                   s_axi_rresp,
  input logic                         s_axi_rvalid,
  input logic                         s_axi_rready,
  input logic                         mode_det_enable,
  input sdrs_pkg::sdrs_rate_mode_t    det_mode,
  input logic                         det_mode_locked,
  input logic                         det_level_b,
  input sdrs_pkg::sdrs_stream_count_t det_streams,
  input logic [3:0]                   ts_rate,
  input logic [3:0]                   ts_family,
  input logic                         ts_scan,
  input logic                         ts_locked,
  input logic [31:0]                  payload_in,
  input logic                         payload_in_ok
);
  import sdrs_pkg::*;
  logic [1:0] since_rst; // edges since reset
  logic [4:0] rd_word;   // word index of the read address
  logic       rd_take;   // read with full history
  logic       rd_first;  // read at first edge
  logic       rd_map;    // read address hits a mapped word
  assign rd_word  = s_axi_araddr[6:2];
  assign rd_take  = s_axi_arvalid && s_axi_arready && (since_rst == 2'h3);
  assign rd_first = s_axi_arvalid && s_axi_arready && (since_rst == 2'h0);
  assign rd_map   = rd_word inside {5'h06, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12};

  // saturating edge count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since_rst <= 2'h0;
    end else if (since_rst != 2'h3) begin
      since_rst <= since_rst + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_stream15;
    rd_take && rd_word == 5'h0E && $past(payload_in_ok)
    |=> s_axi_rdata == $past(payload_in, 2);
  endproperty
  a_stream15: assert property (p_stream15)
    else $error("stream 15 word differs from captured bytes");
  property p_valid;
    rd_take && rd_word == 5'h06
    |=> s_axi_rdata == {24'h0, $past(payload_in_ok, 2), 7'h0};
  endproperty
  a_valid: assert property (p_valid)
    else $error("stream 15 valid bit wrong");
  property p_version;
    rd_take && rd_word == 5'h0F |=> s_axi_rdata == {`SDRS_VER_MAJOR,
      `SDRS_VER_MINOR, `SDRS_VER_REV, `SDRS_VER_PATCH, `SDRS_VER_INTERNAL};
  endproperty
  a_version: assert property (p_version)
    else $error("version word wrong");
  property p_cfg;
    rd_take && rd_word == 5'h10 |=> s_axi_rdata ==
      {30'h0, BUILD_WITH_ERROR_PACKET_PROCESSOR, 1'b0};
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("build flag word wrong");
  property p_mode_word;
    rd_take && rd_word == 5'h11 |=> s_axi_rdata == {24'h0,
      $past(det_level_b, 2), $past(det_streams, 2),
      !$past(mode_det_enable, 2) || $past(det_mode_locked, 2),
      $past(det_mode, 2)};
  endproperty
  a_mode_word: assert property (p_mode_word)
    else $error("rate mode word wrong");
  property p_transport;
    rd_take && rd_word == 5'h12 |=> s_axi_rdata == {20'h0,
      $past(ts_rate, 2), $past(ts_family, 2), 2'h0,
      $past(ts_scan, 2), $past(ts_locked, 2)};
  endproperty
  a_transport: assert property (p_transport)
    else $error("transport word wrong");
  property p_rst_mode;
    rd_first && rd_word == 5'h11 |=> s_axi_rdata == 32'h0000_0018;
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("rate mode word not at reset value");
  property p_rst_ts;
    rd_first && rd_word == 5'h12 |=> s_axi_rdata == 32'h0000_00F0;
  endproperty
  a_rst_ts: assert property (p_rst_ts)
    else $error("transport word not at reset value");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && !rd_map
    |=> s_axi_rdata == 32'h0 && s_axi_rresp == `SDRS_RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");

  c_mode_read: cover property (rd_take && rd_word == 5'h11);
  c_unmapped: cover property (s_axi_arvalid && s_axi_arready && !rd_map);
  c_stall: cover property ((s_axi_rvalid && !s_axi_rready) [*2]);
endmodule

bind sdrs_status_regs sdrs_status_regs_checker #(
  .BUILD_WITH_ERROR_PACKET_PROCESSOR(BUILD_WITH_ERROR_PACKET_PROCESSOR)
) u_checker (.*);

// file: testbench/sdi_rx_status_regs_tb_top.sv
`timescale 1ns/1ps
`include "sdrs_params.svh"

// ****
// bench
// ****
module sdi_rx_status_regs_tb_top;
  import sdrs_pkg::*;
  logic        clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, mode_det_enable;
  logic        det_mode_locked, det_level_b, ts_scan, ts_locked;
  logic        payload_in_ok;
  logic [6:0]  s_axi_awaddr, s_axi_araddr, a;
  logic [31:0] s_axi_wdata, s_axi_rdata, payload_in, pl_last, d;
  logic [3:0]  s_axi_wstrb, ts_rate, ts_family;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          miscompares, n_compared;
  sdrs_rate_mode_t    det_mode;
  sdrs_stream_count_t det_streams;
  sdrs_rate_mode_t    mode_tab [6] = '{SDRS_MODE_HD, SDRS_MODE_SD,
    SDRS_MODE_3G, SDRS_MODE_6G, SDRS_MODE_12G, SDRS_MODE_12G_DIV};
  sdrs_stream_count_t strm_tab [5] = '{SDRS_STREAMS_1, SDRS_STREAMS_2,
    SDRS_STREAMS_4, SDRS_STREAMS_8, SDRS_STREAMS_16};
  logic [6:0]  map_tab [6] = '{7'h18, 7'h38, 7'h3C, 7'h40, 7'h44, 7'h48};
  logic [6:0]  rst_adr [4] = '{7'h38, 7'h18, 7'h44, 7'h48};
  logic [31:0] rst_val [4] = '{32'h0, 32'h0, 32'h18, 32'hF0};

  sdrs_status_regs dut (.*);

  // free-running bus clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****
  // checks
  // ****
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: %s got %h exp %h", $time, what, got,
        exp);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // expected read word
  function automatic logic [31:0] exp_word(input logic [6:0] adr);
    case (adr[6:2])
      5'h06: return {24'h0, payload_in_ok, 7'h0};
      5'h0E: return pl_last;
      5'h0F: return {`SDRS_VER_MAJOR, `SDRS_VER_MINOR, `SDRS_VER_REV,
        `SDRS_VER_PATCH, `SDRS_VER_INTERNAL};
      5'h10: return 32'h0000_0002;
      5'h11: return {24'h0, det_level_b, det_streams,
        !mode_det_enable || det_mode_locked, det_mode};
      5'h12: return {20'h0, ts_rate, ts_family, 2'h0, ts_scan, ts_locked};
      default: return 32'h0;
    endcase
  endfunction

  // ****
  // drivers
  // ****
  task automatic set_in(input sdrs_rate_mode_t m,
    input sdrs_stream_count_t s, input logic en, lk);
    logic [31:0] p;
    logic        o;
    p = $urandom;
    o = 1'($urandom);
    if (o) pl_last = p;
    payload_in <= p;
    payload_in_ok <= o;
    det_mode <= m;
    det_streams <= s;
    mode_det_enable <= en;
    det_mode_locked <= lk;
    det_level_b <= 1'($urandom);
    ts_rate <= 4'($urandom);
    ts_family <= 4'($urandom);
    ts_scan <= 1'($urandom);
    ts_locked <= 1'($urandom);
    @(posedge clk);
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    pl_last = payload_in_ok ? payload_in : 32'h0;
  endtask

  task automatic rd(input logic [6:0] adr, input int stall,
    output logic [31:0] dat, output logic [1:0] rsp);
    s_axi_araddr <= adr;
    s_axi_arvalid <= 1'b1;
    @(negedge clk);
    chk(32'(s_axi_arready), 32'h1, "arready");
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    repeat (stall) @(posedge clk);
    s_axi_rready <= 1'b1;
    @(negedge clk);
    chk(32'(s_axi_rvalid), 32'h1, "rvalid");
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [6:0] adr, input int stall);
    logic [31:0] dat;
    logic [1:0]  rsp;
    rd(adr, stall, dat, rsp);
    chk(dat, exp_word(adr), "read data");
    chk(32'(rsp), (adr[6:2] inside {5'h06, 5'h0E, 5'h0F, 5'h10, 5'h11,
      5'h12}) ? `SDRS_RESP_OKAY : `SDRS_RESP_SLVERR, "read resp");
  endtask

  // gap: idle cycles between address and data
  task automatic wr(input logic [6:0] adr, input int gap,
    output logic [1:0] rsp);
    s_axi_awaddr <= adr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= $urandom;
    s_axi_wstrb <= 4'($urandom);
    s_axi_wvalid <= (gap == 0);
    @(negedge clk);
    chk(32'(s_axi_awready), 32'h1, "awready");
    @(posedge clk);
    s_axi_awvalid <= 1'b0;
    if (gap != 0) begin
      repeat (gap) @(posedge clk);
      s_axi_wvalid <= 1'b1;
      @(negedge clk);
      chk(32'(s_axi_wready), 32'h1, "wready");
      @(posedge clk);
    end
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    @(negedge clk);
    chk(32'(s_axi_bvalid), 32'h1, "bvalid");
    rsp = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask

  // ****
  // tests
  // ****
  initial begin
    reset_n = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
      s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    {mode_det_enable, det_mode_locked, det_level_b, ts_rate, ts_family,
      ts_scan, ts_locked, payload_in, payload_in_ok, pl_last} = '0;
    det_mode = SDRS_MODE_HD;
    det_streams = SDRS_STREAMS_2;
    void'($urandom(24304));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    // reset values
    for (int i = 0; i < 4; i++) begin
      set_in(SDRS_MODE_12G, SDRS_STREAMS_16, 1'b1, 1'b0);
      do_reset();
      rd(rst_adr[i], 0, d, r);
      chk(d, rst_val[i], "reset value");
    end
    $display("test reset values done");
    // rate and stream codes
    for (int i = 0; i < 6; i++) begin
      set_in(mode_tab[i], strm_tab[i % 5], 1'(i), 1'b0);
      rd_chk(7'h44, 0);
    end
    $display("test mode codes done");
    // random reads
    repeat (60) begin
      set_in(mode_tab[$urandom_range(0, 5)], strm_tab[$urandom_range(0, 4)],
        1'($urandom), 1'($urandom));
      a = map_tab[$urandom_range(0, 5)] | 7'($urandom_range(0, 3));
      if ($urandom_range(0, 3) == 0) a = 7'($urandom);
      rd_chk(a, $urandom_range(0, 2));
    end
    $display("test random reads done");
    // writes
    set_in(SDRS_MODE_6G, SDRS_STREAMS_4, 1'b1, 1'b1);
    wr(7'h44, 0, r);
    chk(32'(r), `SDRS_RESP_OKAY, "write resp");
    wr(7'h38, 2, r);
    chk(32'(r), `SDRS_RESP_OKAY, "write resp");
    wr(7'h7C, 1, r);
    chk(32'(r), `SDRS_RESP_SLVERR, "write resp");
    rd_chk(7'h44, 0);
    rd_chk(7'h38, 3);
    $display("test writes done");
    stop_test();
  end

  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    $display("wrong value at %0t ns: run timed out", $time);
    stop_test();
  end
endmodule
